// ===== timer_counter_pair.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - timer 0 mode 2 counts low byte, reloads it from high byte on overflow.
// - high byte write in mode 2 sets next reload, low count untouched.
// - timer 0 mode 3 low byte is its own 8-bit timer with timer 0 controls.
// - timer 0 mode 3 high byte counts clock/6, timer 1 run, sets timer 1 flag.
// - timer 1 in mode 3 stops and holds its count.
// - timer 1 uses upper mode nibble and control bits 6, 7.
// - gate clear lets run enable counting; gate set adds that timer's interrupt pin.
// - timer 1 rollover to zero sets timer 1 overflow flag unless timer 0 is in mode 3.
// - mode 0 is 13-bit: 5-bit prescaler carries into high byte.
// - mode 1 is a 16-bit cascade of low and high bytes.
// - timer 1 mode 2 reloads low byte from high byte on overflow.
// - modes 0 to 2 count clock or pin per counter-select bit.
// - each overflow flag set per overflow, cleared on vectoring.
// - request reaches processor only with timer and global enable set.
// - timer 1 overflows feed serial port baud clock.
// - timer mode counts once per six-clock peripheral cycle.
// - counter mode counts a high-then-low pair of per-cycle pin samples.
// - gate set: timer 1 counts only while pin high, and run set unless timer 0 is in mode 3.
// - timer 0 uses lower mode nibble and control bits 4, 5.
module timer_counter_pair
   import timer_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // write address channel
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [7:0] AWADDR,
   // write data channel
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // write response channel
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // read address channel
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [7:0] ARADDR,
   // read data channel
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // external pins
   input wire logic TIMER0_PIN,
   input wire logic TIMER1_PIN,
   input wire logic EXT_IRQ0_N,
   input wire logic EXT_IRQ1_N,
   // interrupt controller
   input wire logic TIMER0_ACK,
   input wire logic TIMER1_ACK,
   output logic TIMER0_IRQ,
   output logic TIMER1_IRQ,
   // serial port baud source
   output logic BAUD_TICK
);

   logic [2:0] prescale;
   logic [2:0] next_prescale;
   logic tick;

   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [7:0] w_data, next_w_data;
   logic w_lane, next_w_lane;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_fire;

   logic [7:0] control, next_control;
   logic [7:0] mode_reg, next_mode_reg;
   logic [7:0] irq_en, next_irq_en;
   count_type t0, next_t0, t1, next_t1;
   logic ext0_prev, ext1_prev;
   logic next_irq0, next_irq1, next_baud;

   timer_cfg_type cfg0, cfg1;
   logic t0_split, inc0, inc1, t1_run;
   logic low_ovf, split_high_ovf, t0_ovf_set, t1_ovf_set;
   step_type step0, step1;

   // true for every address that holds a register
   function automatic logic is_mapped(logic [7:0] a);
      case (a)
         CONTROL_OFFSET, MODE_OFFSET, T0_LOW_OFFSET, T0_HIGH_OFFSET,
         T1_LOW_OFFSET, T1_HIGH_OFFSET, IRQ_ENABLE_OFFSET: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // peripheral cycle divider
   always_comb
   begin
      next_prescale = (prescale == PRESCALE_LAST) ? 3'h0 : prescale + 3'h1;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         prescale <= 3'h0;
      else
         prescale <= next_prescale;
   end

   assign tick = (prescale == PRESCALE_LAST);

   // configuration nibbles
   assign cfg0 = timer_cfg_type'(mode_reg[T0_CFG_LSB +: 4]);
   assign cfg1 = timer_cfg_type'(mode_reg[T1_CFG_LSB +: 4]);
   assign t0_split = (cfg0.mode == MODE_SPLIT);
   // run bit is lent to timer 0 high byte in split mode
   assign t1_run = t0_split ? 1'b1 : control[T1_RUN_BIT];

   // event sources for both timers
   count_source src0 (
      .clk(CLK),
      .srst(SRST),
      .tick(tick),
      .run(control[T0_RUN_BIT]),
      .gate(cfg0.gate),
      .gate_pin_level(EXT_IRQ0_N),
      .counter_select(cfg0.counter_select),
      .count_pin(TIMER0_PIN),
      .inc(inc0)
   );

   count_source src1 (
      .clk(CLK),
      .srst(SRST),
      .tick(tick),
      .run(t1_run),
      .gate(cfg1.gate),
      .gate_pin_level(EXT_IRQ1_N),
      .counter_select(cfg1.counter_select),
      .count_pin(TIMER1_PIN),
      .inc(inc1)
   );

   // bus channels: address and data taken in either order
   always_comb
   begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_lane = w_lane;
      next_bvalid = BVALID;
      next_bresp = BRESP;
      next_rvalid = RVALID;
      next_rdata = RDATA;
      next_rresp = RRESP;
      wr_fire = aw_held & w_held & ~BVALID;
      if (AWVALID && AWREADY)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR;
      end
      if (WVALID && WREADY)
      begin
         next_w_held = 1'b1;
         next_w_data = WDATA[7:0];
         next_w_lane = WSTRB[0];
      end
      if (wr_fire)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID && BREADY)
      begin
         next_bvalid = 1'b0;
      end
      if (ARVALID && ARREADY)
      begin
         // counts readable at any moment
         next_rvalid = 1'b1;
         next_rresp = is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
         case (ARADDR)
            CONTROL_OFFSET: next_rdata = {24'h000000, control};
            MODE_OFFSET: next_rdata = {24'h000000, mode_reg};
            T0_LOW_OFFSET: next_rdata = {24'h000000, t0.low};
            T0_HIGH_OFFSET: next_rdata = {24'h000000, t0.high};
            T1_LOW_OFFSET: next_rdata = {24'h000000, t1.low};
            T1_HIGH_OFFSET: next_rdata = {24'h000000, t1.high};
            IRQ_ENABLE_OFFSET: next_rdata = {24'h000000, irq_en};
            default: next_rdata = 32'h00000000;
         endcase
      end
      else if (RVALID && RREADY)
      begin
         next_rvalid = 1'b0;
      end
      // one transfer per direction in flight
      next_awready = ~next_aw_held & ~next_bvalid;
      next_wready = ~next_w_held & ~next_bvalid;
      next_arready = ~next_rvalid;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 8'h00;
         w_lane <= 1'b0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= RESP_OKAY;
      end
      else
      begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_lane <= next_w_lane;
         AWREADY <= next_awready;
         WREADY <= next_wready;
         BVALID <= next_bvalid;
         BRESP <= next_bresp;
         ARREADY <= next_arready;
         RVALID <= next_rvalid;
         RDATA <= next_rdata;
         RRESP <= next_rresp;
      end
   end

   // counting, software writes, flags and requests
   always_comb
   begin
      step0 = step_count(t0, cfg0.mode, inc0);
      step1 = step_count(t1, cfg1.mode, inc1); // mode 3 holds
      low_ovf = 1'b0;
      split_high_ovf = 1'b0;
      next_t0 = step0.count;
      next_t1 = step1.count;
      if (t0_split)
      begin
         // low byte on timer 0 controls
         next_t0.low = inc0 ? t0.low + 8'h01 : t0.low;
         low_ovf = inc0 & (t0.low == 8'hFF);
         // high byte always on the divided clock, timer 1 run
         if (tick && control[T1_RUN_BIT])
         begin
            next_t0.high = t0.high + 8'h01;
            split_high_ovf = (t0.high == 8'hFF);
         end
      end
      t0_ovf_set = t0_split ? low_ovf : step0.overflow;
      // split high byte takes over the timer 1 flag
      t1_ovf_set = t0_split ? split_high_ovf : step1.overflow;
      next_control = control;
      next_mode_reg = mode_reg;
      next_irq_en = irq_en;
      // software store; high byte write leaves low count
      if (wr_fire && w_lane)
      begin
         case (aw_addr)
            CONTROL_OFFSET: next_control = w_data;
            MODE_OFFSET: next_mode_reg = w_data;
            T0_LOW_OFFSET: next_t0.low = w_data;
            T0_HIGH_OFFSET: next_t0.high = w_data;
            T1_LOW_OFFSET: next_t1.low = w_data;
            T1_HIGH_OFFSET: next_t1.high = w_data;
            IRQ_ENABLE_OFFSET: next_irq_en = w_data;
            default: next_control = control;
         endcase
      end
      // ack clears, a same-cycle overflow still sets
      next_control[T0_OVF_BIT] = (next_control[T0_OVF_BIT] & ~TIMER0_ACK)
                                 | t0_ovf_set;
      next_control[T1_OVF_BIT] = (next_control[T1_OVF_BIT] & ~TIMER1_ACK)
                                 | t1_ovf_set;
      // edge type latches a fall, level type latches a low pin
      next_control[EXT0_EDGE_BIT] = next_control[EXT0_EDGE_BIT]
         | (control[EXT0_TYPE_BIT] ? (ext0_prev & ~EXT_IRQ0_N) : ~EXT_IRQ0_N);
      next_control[EXT1_EDGE_BIT] = next_control[EXT1_EDGE_BIT]
         | (control[EXT1_TYPE_BIT] ? (ext1_prev & ~EXT_IRQ1_N) : ~EXT_IRQ1_N);
      // timer and global enable both needed
      next_irq0 = next_control[T0_OVF_BIT] & next_irq_en[T0_IRQ_EN_BIT]
                  & next_irq_en[GLOBAL_IRQ_EN_BIT];
      next_irq1 = next_control[T1_OVF_BIT] & next_irq_en[T1_IRQ_EN_BIT]
                  & next_irq_en[GLOBAL_IRQ_EN_BIT];
      // baud source sees timer 1 overflows even without a flag
      next_baud = step1.overflow;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         control <= CONTROL_RESET;
         mode_reg <= MODE_RESET;
         irq_en <= IRQ_ENABLE_RESET;
         t0 <= {COUNT_RESET, COUNT_RESET};
         t1 <= {COUNT_RESET, COUNT_RESET};
         ext0_prev <= 1'b1;
         ext1_prev <= 1'b1;
         TIMER0_IRQ <= 1'b0;
         TIMER1_IRQ <= 1'b0;
         BAUD_TICK <= 1'b0;
      end
      else
      begin
         control <= next_control;
         mode_reg <= next_mode_reg;
         irq_en <= next_irq_en;
         t0 <= next_t0;
         t1 <= next_t1;
         ext0_prev <= EXT_IRQ0_N;
         ext1_prev <= EXT_IRQ1_N;
         TIMER0_IRQ <= next_irq0;
         TIMER1_IRQ <= next_irq1;
         BAUD_TICK <= next_baud;
      end
   end

endmodule

// ===== timer_pkg.sv
package timer_pkg;

   // one peripheral cycle is six clocks
   localparam int PER_CYCLE_CLKS = 6;
   localparam logic [2:0] PRESCALE_LAST = 3'(PER_CYCLE_CLKS - 1);

   // register byte addresses
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] MODE_OFFSET = 8'h04;
   localparam logic [7:0] T0_LOW_OFFSET = 8'h08;
   localparam logic [7:0] T0_HIGH_OFFSET = 8'h0C;
   localparam logic [7:0] T1_LOW_OFFSET = 8'h10;
   localparam logic [7:0] T1_HIGH_OFFSET = 8'h14;
   localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h18;

   // control register bit positions
   localparam int EXT0_TYPE_BIT = 0;
   localparam int EXT0_EDGE_BIT = 1;
   localparam int EXT1_TYPE_BIT = 2;
   localparam int EXT1_EDGE_BIT = 3;
   localparam int T0_RUN_BIT = 4;
   localparam int T0_OVF_BIT = 5;
   localparam int T1_RUN_BIT = 6;
   localparam int T1_OVF_BIT = 7;

   // mode register: timer 0 in the low nibble, timer 1 in the high one
   localparam int T0_CFG_LSB = 0;
   localparam int T1_CFG_LSB = 4;

   // interrupt enable register bit positions
   localparam int T0_IRQ_EN_BIT = 1;
   localparam int T1_IRQ_EN_BIT = 3;
   localparam int GLOBAL_IRQ_EN_BIT = 7;

   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_PRESCALED = 2'h0,
      MODE_CASCADE = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } timer_mode_type;

   // one nibble of the mode register
   typedef struct packed {
      logic gate;
      logic counter_select;
      timer_mode_type mode;
   } timer_cfg_type;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } count_type;

   typedef struct packed {
      count_type count;
      logic overflow;
   } step_type;

   // one count step for modes 0, 1 and 2; mode 3 holds the count
   function automatic step_type step_count(count_type c, timer_mode_type m,
                                           logic inc);
      step_type s;
      s.count = c;
      s.overflow = 1'b0;
      if (inc)
      begin
         case (m)
            MODE_PRESCALED:
            begin
               // upper three low-byte bits left untouched
               s.count.low[4:0] = c.low[4:0] + 5'h01;
               if (c.low[4:0] == 5'h1F)
               begin
                  s.count.high = c.high + 8'h01;
                  s.overflow = (c.high == 8'hFF);
               end
            end
            MODE_CASCADE:
            begin
               // low byte carry feeds the high byte
               s.count = count_type'({c.high, c.low} + 16'h0001);
               s.overflow = ({c.high, c.low} == 16'hFFFF);
            end
            MODE_RELOAD:
            begin
               // reload from high byte, high byte kept
               if (c.low == 8'hFF)
               begin
                  s.count.low = c.high;
                  s.overflow = 1'b1;
               end
               else
               begin
                  s.count.low = c.low + 8'h01;
               end
            end
            default:
            begin
               s.count = c;
            end
         endcase
      end
      return s;
   endfunction

endpackage

// ===== count_source.sv
`timescale 1ns/1ps
module count_source
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // peripheral cycle strobe
   input wire logic tick,
   // controls
   input wire logic run,
   input wire logic gate,
   input wire logic gate_pin_level,
   input wire logic counter_select,
   // external count pin
   input wire logic count_pin,
   // one increment
   output logic inc
);

   logic sample;
   logic next_sample;
   logic enabled;
   logic source_event;

   // pin sampled once per peripheral cycle
   always_comb
   begin
      next_sample = sample;
      if (tick)
      begin
         next_sample = count_pin;
      end
   end

   // reset to low so no false edge follows reset
   always_ff @(posedge clk)
   begin
      if (srst)
         sample <= 1'b0;
      else
         sample <= next_sample;
   end

   // gate open only while the interrupt pin is high
   assign enabled = run & (~gate | gate_pin_level);
   // high then low across two samples is one count
   assign source_event = counter_select ? (sample & ~count_pin) : 1'b1;
   assign inc = tick & enabled & source_event;

endmodule

// ===== timer_counter_pair_chk.sv
`timescale 1ns/1ps
module timer_counter_pair_chk
   import timer_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [1:0] BRESP,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [7:0] ARADDR,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   // interrupt side and baud
   input wire logic TIMER0_ACK,
   input wire logic TIMER0_IRQ,
   input wire logic TIMER1_ACK,
   input wire logic TIMER1_IRQ,
   input wire logic BAUD_TICK
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   // answers come in bounded time once both halves are in
   a_write_answer: assert property
      (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
      else $error("write answer missing");
   a_read_answer: assert property
      (ARVALID && ARREADY |=> RVALID)
      else $error("read answer missing");
   a_resp_hold: assert property
      (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write answer dropped");
   a_rdata_hold: assert property
      (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   a_busy_refuse: assert property
      (BVALID |-> !AWREADY && !WREADY)
      else $error("write taken while answering");
   a_unmapped_read: assert property
      (ARVALID && ARREADY && ARADDR == 8'h1C
      |=> RRESP == RESP_SLVERR && RDATA == 32'h0)
      else $error("unmapped read not refused");
   // vectoring clears the request on the next edge
   a_ack0_clears: assert property
      (TIMER0_ACK |=> !TIMER0_IRQ)
      else $error("timer 0 request stays after ack");
   a_ack1_clears: assert property
      (TIMER1_ACK |=> !TIMER1_IRQ)
      else $error("timer 1 request stays after ack");
   // overflows cannot come faster than one per peripheral cycle
   a_baud_spacing: assert property
      (BAUD_TICK |=> !BAUD_TICK [*5])
      else $error("baud ticks too close");

   c_baud: cover property (BAUD_TICK);
   c_irq0: cover property ($rose(TIMER0_IRQ));
   c_ack1: cover property (TIMER1_ACK);
endmodule

bind timer_counter_pair timer_counter_pair_chk chk_u (.CLK, .SRST,
   .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .BRESP,
   .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
   .TIMER0_ACK, .TIMER0_IRQ, .TIMER1_ACK, .TIMER1_IRQ, .BAUD_TICK);

// ===== timer_far_side.sv
`timescale 1ns/1ps
module timer_far_side
(
   // clock and requests
   input wire logic CLK,
   input wire logic TIMER0_IRQ,
   input wire logic TIMER1_IRQ,
   // pins and vector acknowledges
   output logic TIMER0_PIN,
   output logic TIMER1_PIN,
   output logic EXT_IRQ0_N,
   output logic EXT_IRQ1_N,
   output logic TIMER0_ACK,
   output logic TIMER1_ACK
);
   logic ack_en;

   // idle pins high, no vectoring until asked
   initial
   begin
      TIMER0_PIN <= 1'b1;
      TIMER1_PIN <= 1'b1;
      EXT_IRQ0_N <= 1'b1;
      EXT_IRQ1_N <= 1'b1;
      TIMER0_ACK <= 1'b0;
      TIMER1_ACK <= 1'b0;
      ack_en <= 1'b0;
   end

   // each level held two peripheral cycles so no sample misses it
   task automatic pulses(input logic sel, input int n);
      repeat (n)
      begin
         repeat (12) @(posedge CLK);
         if (sel)
            TIMER1_PIN <= 1'b0;
         else
            TIMER0_PIN <= 1'b0;
         repeat (12) @(posedge CLK);
         TIMER1_PIN <= 1'b1;
         TIMER0_PIN <= 1'b1;
      end
      repeat (12) @(posedge CLK);
   endtask

   // vector taken one cycle after a request is seen, one-cycle pulse
   always @(posedge CLK)
   begin
      TIMER0_ACK <= ack_en && TIMER0_IRQ && !TIMER0_ACK;
      TIMER1_ACK <= ack_en && TIMER1_IRQ && !TIMER1_ACK;
   end
endmodule

// ===== timer_counter_pair_tb_top.sv
`timescale 1ns/1ps
module timer_counter_pair_tb_top;
   import timer_pkg::*;
   logic CLK, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic ARVALID, ARREADY, RVALID, RREADY, BAUD_TICK;
   logic TIMER0_PIN, TIMER1_PIN, EXT_IRQ0_N, EXT_IRQ1_N;
   logic TIMER0_ACK, TIMER1_ACK, TIMER0_IRQ, TIMER1_IRQ;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   int errors = 0;
   int compares = 0;

   timer_counter_pair dut_u (.CLK, .SRST, .AWVALID, .AWREADY, .AWADDR,
      .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP,
      .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
      .TIMER0_PIN, .TIMER1_PIN, .EXT_IRQ0_N, .EXT_IRQ1_N, .TIMER0_ACK,
      .TIMER1_ACK, .TIMER0_IRQ, .TIMER1_IRQ, .BAUD_TICK);
   timer_far_side partner_u (.CLK, .TIMER0_IRQ, .TIMER1_IRQ, .TIMER0_PIN,
      .TIMER1_PIN, .EXT_IRQ0_N, .EXT_IRQ1_N, .TIMER0_ACK, .TIMER1_ACK);

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // bus cycles; the expected response follows from the address map
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      AWVALID <= 1'b1;
      AWADDR <= a;
      WVALID <= 1'b1;
      WDATA <= {24'h000000, d};
      fork
         begin
            do @(posedge CLK); while (AWREADY !== 1'b1);
            AWVALID <= 1'b0;
         end
         begin
            do @(posedge CLK); while (WREADY !== 1'b1);
            WVALID <= 1'b0;
         end
      join
      BREADY <= 1'b1;
      do @(posedge CLK); while (BVALID !== 1'b1);
      BREADY <= 1'b0;
      check("bresp", 32'(BRESP),
            a > IRQ_ENABLE_OFFSET ? RESP_SLVERR : RESP_OKAY);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      ARVALID <= 1'b1;
      ARADDR <= a;
      do @(posedge CLK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      RREADY <= 1'b1;
      do @(posedge CLK); while (RVALID !== 1'b1);
      RREADY <= 1'b0;
      d = RDATA;
      check("rresp", 32'(RRESP),
            a > IRQ_ENABLE_OFFSET ? RESP_SLVERR : RESP_OKAY);
   endtask

   // n counted events on {high, low}; returns {overflow, high, low}
   function automatic logic [16:0] model(logic [15:0] c, logic [1:0] m,
                                         logic t0, int n);
      logic ov;
      ov = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         if (m == 2'h0)
         begin
            ov |= (c[4:0] == 5'h1F && c[15:8] == 8'hFF);
            if (c[4:0] == 5'h1F)
               c[15:8] = c[15:8] + 8'h01;
            c[4:0] = c[4:0] + 5'h01;
         end
         else if (m == 2'h1)
         begin
            ov |= (c == 16'hFFFF);
            c = c + 16'h0001;
         end
         else if (m == 2'h2 || t0)
         begin
            ov |= (c[7:0] == 8'hFF);
            if (c[7:0] == 8'hFF && m == 2'h2)
               c[7:0] = c[15:8];
            else
               c[7:0] = c[7:0] + 8'h01;
         end
      end
      return {ov, c};
   endfunction

   // one counter-mode run of timer t in mode m, gated at random
   task automatic run_case(input logic t, input logic [1:0] m);
      logic [16:0] e, e1;
      logic [31:0] d;
      logic [7:0] lo, hi, h2, base, en;
      logic g, pin;
      int n1, n2;
      base = t ? T1_LOW_OFFSET : T0_LOW_OFFSET;
      lo = 8'hF8 | 8'($urandom_range(7));
      hi = (m < 2'h2) ? 8'hFF : 8'($urandom);
      h2 = 8'($urandom);
      g = 1'($urandom);
      pin = 1'($urandom);
      n1 = (!g || pin) ? $urandom_range(5, 1) : 0;
      n2 = (!g || pin) ? $urandom_range(5, 0) : 0;
      partner_u.EXT_IRQ0_N <= pin;
      partner_u.EXT_IRQ1_N <= pin;
      wr(MODE_OFFSET, {4'h0, g, 1'b1, m} << (t ? 4 : 0));
      wr(base, lo);
      wr(base + 8'h04, hi);
      wr(CONTROL_OFFSET, t ? 8'h40 : 8'h10);
      partner_u.pulses(t, g && !pin ? 2 : n1);
      e = model({hi, lo}, m, !t, n1);
      if (m == 2'h2)
      begin
         wr(base + 8'h04, h2);
         e[15:8] = h2;
      end
      partner_u.pulses(t, n2);
      e1 = model(e[15:0], m, !t, n2);
      e1[16] = e1[16] | e[16];
      rd(CONTROL_OFFSET, d);
      check("overflow flag", 32'(d[t ? 7 : 5]), 32'(e1[16]));
      en = 8'($urandom) & 8'h8A;
      wr(IRQ_ENABLE_OFFSET, en);
      @(posedge CLK);
      check("irq", 32'(t ? TIMER1_IRQ : TIMER0_IRQ),
            32'(e1[16] & en[7] & en[t ? 3 : 1]));
      wr(IRQ_ENABLE_OFFSET, 8'h8A);
      partner_u.ack_en <= 1'b1;
      repeat (4) @(posedge CLK);
      partner_u.ack_en <= 1'b0;
      rd(CONTROL_OFFSET, d);
      check("flag after ack", 32'(d[t ? 7 : 5]), 32'h0);
      wr(CONTROL_OFFSET, 8'h00);
      rd(base, d);
      check("count low", d, {24'h0, e1[7:0]});
      rd(base + 8'h04, d);
      check("count high", d, {24'h0, e1[15:8]});
   endtask

   // baud pulses seen over 120 clocks
   task automatic baud_count(input logic [31:0] exp);
      int nb;
      nb = 0;
      repeat (120)
      begin
         @(posedge CLK);
         nb += int'(BAUD_TICK);
      end
      check("baud ticks", 32'(nb), exp);
   endtask

   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   initial
   begin
      #200000;
      errors++;
      end_sim;
   end

   initial
   begin
      logic [31:0] d;
      void'($urandom(32'h2B6A439C));
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} <= 5'h00;
      {AWADDR, ARADDR, WDATA} <= 48'h0;
      WSTRB <= 4'hF;
      SRST <= 1'b1;
      repeat (6) @(posedge CLK);
      SRST <= 1'b0;
      for (int a = 0; a <= 28; a += 4)
      begin
         rd(8'(a), d);
         check("reset value", d, 32'h0);
      end
      // byte lane 0 switched off: the store must be dropped
      WSTRB <= 4'hE;
      wr(T0_LOW_OFFSET, 8'h5A);
      WSTRB <= 4'hF;
      rd(T0_LOW_OFFSET, d);
      check("masked store", d, 32'h0);
      for (int r = 0; r < 2; r++)
         for (int t = 0; t < 2; t++)
            for (int m = 0; m < 4; m++)
               run_case(1'(t), 2'(m));
      wr(MODE_OFFSET, 8'h23);
      wr(T0_HIGH_OFFSET, 8'hF0);
      wr(T1_HIGH_OFFSET, 8'hFF);
      wr(T1_LOW_OFFSET, 8'hFF);
      wr(CONTROL_OFFSET, 8'h40);
      baud_count(32'h14);
      rd(CONTROL_OFFSET, d);
      check("split high overflow", 32'(d[7]), 32'h1);
      wr(MODE_OFFSET, 8'h33);
      baud_count(32'h0);
      end_sim;
   end
endmodule
